// [logic/ras_pkg.sv]
// Package for the return-address stack: register map, field layout, sizes.
// Assumes a single 20 MHz core clock and an AHB-Lite register slave.
package ras_pkg;

	localparam int PC_W = 21;
	localparam int SP_W = 5;
	localparam int DEPTH = 31;
	localparam logic [SP_W-1:0] SP_MAX = 5'h1f;
	localparam logic [SP_W-1:0] SP_RST = 5'h00;
	localparam logic [PC_W-1:0] VEC_RESET = 21'h000000;
	localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
	localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	// Implemented program words for the two variants
	localparam int WORDS_LARGE = 16384;
	localparam int WORDS_SMALL = 8192;

	// Register byte offsets
	localparam logic [7:0] OFS_SP = 8'h00;
	localparam logic [7:0] OFS_TOP_UPPER = 8'h04;
	localparam logic [7:0] OFS_TOP_HIGH = 8'h08;
	localparam logic [7:0] OFS_TOP_LOW = 8'h0c;
	localparam logic [7:0] OFS_CFG = 8'h10;

	// Pointer and configuration register fields
	localparam int BIT_FULL = 7;
	localparam int BIT_UNF = 6;
	localparam int CFG_OVR_EN = 0;
	localparam logic CFG_RST = 1'b1;

	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_PUSH = 2'b01,
		OP_POP = 2'b11,
		OP_DISCARD = 2'b10
	} stack_op_t;

	typedef struct packed {
		stack_op_t op;
		logic [PC_W-1:0] pc;
	} stack_req_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_DATA = 2'b01
	} bus_state_t;

endpackage

// [logic/return_address_stack.sv]
// Return-address stack of the core with its AHB-Lite register window.
// Assumes the sequencer issues one stack request per cycle, synchronous to clk.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module return_address_stack #(
	parameter int PROG_WORDS = ras_pkg::WORDS_LARGE
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic por_n,
	// Sequencer
	input wire ras_pkg::stack_req_t req,
	output ras_pkg::stack_req_t pop_data,
	output logic stack_reset,
	// Program fetch
	input wire logic [ras_pkg::PC_W-1:0] fetch_addr,
	input wire logic [15:0] fetch_mem_data,
	output logic [15:0] fetch_data,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	import ras_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	// Storage of 31 pc values of 21 bits
	logic [PC_W-1:0] stack_mem [1:DEPTH];
	logic [SP_W-1:0] sp_ff;
	logic full_ff;
	logic unf_ff;
	logic ovr_en_ff;
	logic [7:0] addr_ff;
	logic wr_ff;
	bus_state_t bus_ff;
	logic [PC_W-1:0] top_val;
	logic [PC_W-1:0] nxt_top;
	logic sw_wr;
	logic sw_sp;
	logic sw_up;
	logic sw_hi;
	logic sw_lo;
	logic sw_clr_full;
	logic sw_clr_unf;
	logic push_ev;
	logic pop_ev;
	logic drop_ev;
	logic full_ev;
	logic unf_ev;
	logic [SP_W-1:0] sp_inc;

	function automatic logic [SP_W-1:0] sp_step(input logic [SP_W-1:0] sp, input logic up);
		sp_step = up ? ((sp == SP_MAX) ? SP_MAX : sp + 5'h01) :
			((sp == SP_RST) ? SP_RST : sp - 5'h01);
	endfunction

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bus_ff <= BUS_IDLE;
			addr_ff <= 8'h00;
			wr_ff <= 1'b0;
		end else if (hready) begin
			bus_ff <= (hsel && htrans[1]) ? BUS_DATA : BUS_IDLE;
			addr_ff <= haddr[7:0];
			wr_ff <= hwrite;
		end
	end

	assign sw_wr = (bus_ff == BUS_DATA) && wr_ff;
	assign sw_sp = sw_wr && (addr_ff == OFS_SP);
	assign sw_up = sw_wr && (addr_ff == OFS_TOP_UPPER);
	assign sw_hi = sw_wr && (addr_ff == OFS_TOP_HIGH);
	assign sw_lo = sw_wr && (addr_ff == OFS_TOP_LOW);
	assign sw_clr_full = sw_sp && !hwdata[BIT_FULL];
	assign sw_clr_unf = sw_sp && !hwdata[BIT_UNF];

	// Pointer zero reads as no entry
	assign top_val = (sp_ff == SP_RST) ? VEC_RESET : stack_mem[sp_ff];

	always_comb begin
		nxt_top = top_val;
		if (sw_up)
			nxt_top[20:16] = hwdata[4:0];
		if (sw_hi)
			nxt_top[15:8] = hwdata[7:0];
		if (sw_lo)
			nxt_top[7:0] = hwdata[7:0];
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				OFS_SP: hrdata <= {24'h000000, full_ff, unf_ff, 1'b0, sp_ff};
				OFS_TOP_UPPER: hrdata <= {27'h0000000, top_val[20:16]};
				OFS_TOP_HIGH: hrdata <= {24'h000000, top_val[15:8]};
				OFS_TOP_LOW: hrdata <= {24'h000000, top_val[7:0]};
				OFS_CFG: hrdata <= {31'h00000000, ovr_en_ff};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!por_n)
			ovr_en_ff <= CFG_RST;
		else if (sw_wr && addr_ff == OFS_CFG)
			ovr_en_ff <= hwdata[CFG_OVR_EN];
	end

	// ---------------------------------------------------------------
	// Stack engine
	// ---------------------------------------------------------------
	// Push, pop and discard requests
	assign push_ev = (req.op == OP_PUSH);
	assign pop_ev = (req.op == OP_POP);
	assign drop_ev = (req.op == OP_DISCARD);
	assign sp_inc = sp_step(sp_ff, 1'b1);
	// Full on the push that lands on 31
	assign full_ev = push_ev && (sp_inc == SP_MAX);
	// Underflow on pop or discard of empty stack
	assign unf_ev = (pop_ev || drop_ev) && (sp_ff == SP_RST);

	always_ff @(posedge clk) begin
		if (!nrst)
			sp_ff <= SP_RST;
		else if (push_ev)
			sp_ff <= sp_inc;
		else if (pop_ev || drop_ev)
			// Decrement after read; stays at zero
			sp_ff <= sp_step(sp_ff, 1'b0);
		else if (sw_sp)
			sp_ff <= hwdata[SP_W-1:0];
	end

	// Write the newly selected entry on push, else the top entry on a register write
	always_ff @(posedge clk) begin
		if (push_ev)
			// Overflow with reset enabled stores pc plus two
			stack_mem[sp_inc] <= (full_ev && ovr_en_ff) ? req.pc + PC_STEP : req.pc;
		else if ((sw_up || sw_hi || sw_lo) && sp_ff != SP_RST)
			stack_mem[sp_ff] <= nxt_top;
	end

	// Sticky flags, power-on clears, set beats clear
	always_ff @(posedge clk) begin
		if (!por_n) begin
			full_ff <= 1'b0;
			unf_ff <= 1'b0;
		end else begin
			full_ff <= full_ev || (full_ff && !sw_clr_full);
			unf_ff <= unf_ev || (unf_ff && !sw_clr_unf);
		end
	end

	// Popped value to pc; latches are not touched here
	always_ff @(posedge clk) begin
		if (!nrst)
			pop_data <= '{op: OP_NONE, pc: VEC_RESET};
		else if (pop_ev)
			pop_data <= '{op: OP_POP, pc: top_val};
		else
			pop_data <= '{op: OP_NONE, pc: pop_data.pc};
	end

	// Device reset request after overflow push
	always_ff @(posedge clk) begin
		if (!nrst)
			stack_reset <= 1'b0;
		else
			stack_reset <= full_ev && ovr_en_ff;
	end

	// ---------------------------------------------------------------
	// Program fetch
	// ---------------------------------------------------------------
	// Zero beyond implemented words, own path
	always_ff @(posedge clk) begin
		if (!nrst)
			fetch_data <= 16'h0000;
		else if (fetch_addr[PC_W-1:1] >= 20'(PROG_WORDS))
			fetch_data <= 16'h0000;
		else
			fetch_data <= fetch_mem_data;
	end

	// ---------------------------------------------------------------
	// Assertions: pointer
	// ---------------------------------------------------------------
	sp_reset_a: assert property (@(posedge clk) !nrst |=> sp_ff == SP_RST)
		else $error("pointer not zero after reset");
	push_inc_a: assert property (@(posedge clk) disable iff (!nrst)
		push_ev && sp_ff < 5'h1f |=> sp_ff == $past(sp_ff) + 5'h01)
		else $error("push did not increment pointer");
	pop_dec_a: assert property (@(posedge clk) disable iff (!nrst)
		pop_ev && sp_ff != SP_RST |=> sp_ff == $past(sp_ff) - 5'h01)
		else $error("pop did not decrement pointer");
	full_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		push_ev && sp_ff == SP_MAX |=> sp_ff == SP_MAX)
		else $error("pointer left 31 on overflow");
	sp_write_a: assert property (@(posedge clk) disable iff (!nrst)
		sw_sp && req.op == OP_NONE |=> sp_ff == $past(hwdata[SP_W-1:0]))
		else $error("pointer write lost");

	// ---------------------------------------------------------------
	// Assertions: flags
	// ---------------------------------------------------------------
	full_flag_a: assert property (@(posedge clk) disable iff (!nrst)
		full_ev |=> full_ff && (stack_reset == $past(ovr_en_ff)))
		else $error("full event mishandled");
	flag_sticky_a: assert property (@(posedge clk) disable iff (!por_n)
		full_ff && !sw_clr_full |=> full_ff)
		else $error("full flag dropped");
	unf_flag_a: assert property (@(posedge clk) disable iff (!nrst)
		unf_ev |=> unf_ff)
		else $error("underflow flag not set");
	unf_sticky_a: assert property (@(posedge clk) disable iff (!por_n)
		unf_ff && !sw_clr_unf |=> unf_ff)
		else $error("underflow flag dropped");
	full_clear_a: assert property (@(posedge clk) disable iff (!por_n)
		sw_clr_full && !full_ev |=> !full_ff)
		else $error("full flag not cleared");
	no_reset_a: assert property (@(posedge clk) disable iff (!nrst)
		push_ev && !ovr_en_ff |=> !stack_reset)
		else $error("reset request without enable");
	stack_reset_a: assert property (@(posedge clk) disable iff (!nrst)
		stack_reset |-> $past(full_ev) && $past(ovr_en_ff))
		else $error("reset request without overflow");

	// ---------------------------------------------------------------
	// Assertions: stored data
	// ---------------------------------------------------------------
	push_store_a: assert property (@(posedge clk) disable iff (!nrst)
		push_ev && !full_ev |=> top_val == $past(req.pc))
		else $error("pushed value not at top");
	ovr_store_a: assert property (@(posedge clk) disable iff (!nrst)
		full_ev && ovr_en_ff |=> top_val == $past(req.pc) + PC_STEP)
		else $error("overflow push did not store pc plus two");
	overwrite_a: assert property (@(posedge clk) disable iff (!nrst)
		full_ev && !ovr_en_ff |=> top_val == $past(req.pc))
		else $error("overflow push did not overwrite top");
	pop_value_a: assert property (@(posedge clk) disable iff (!nrst)
		pop_ev |=> pop_data.pc == $past(top_val) && pop_data.op == OP_POP)
		else $error("pop returned wrong value");
	empty_pop_a: assert property (@(posedge clk) disable iff (!nrst)
		pop_ev && sp_ff == SP_RST |=> unf_ff && pop_data.pc == VEC_RESET && sp_ff == SP_RST)
		else $error("empty pop mishandled");
	reset_pc_a: assert property (@(posedge clk) !nrst |=> pop_data.pc == VEC_RESET)
		else $error("pc output not at start address after reset");
	drop_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		drop_ev |=> pop_data.op == OP_NONE)
		else $error("discard drove a pop");
	top_write_a: assert property (@(posedge clk) disable iff (!nrst)
		sw_lo && sp_ff != SP_RST && req.op == OP_NONE |=> top_val[7:0] == $past(hwdata[7:0]))
		else $error("top low write lost");

	// ---------------------------------------------------------------
	// Assertions: bus and fetch
	// ---------------------------------------------------------------
	sp_read_a: assert property (@(posedge clk) disable iff (!nrst)
		hready && hsel && htrans[1] && !hwrite && haddr[7:0] == OFS_SP
		|=> hrdata[7:0] == {$past(full_ff), $past(unf_ff), 1'b0, $past(sp_ff)})
		else $error("pointer read wrong");
	zero_slot_a: assert property (@(posedge clk) disable iff (!nrst)
		sp_ff == SP_RST && hready && hsel && htrans[1] && !hwrite
		&& haddr[7:0] == OFS_TOP_LOW |=> hrdata == 32'h00000000)
		else $error("pointer zero selected an entry");
	fetch_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		fetch_addr[PC_W-1:1] >= 20'(PROG_WORDS) |=> fetch_data == 16'h0000)
		else $error("fetch beyond memory not zero");
	fetch_pass_a: assert property (@(posedge clk) disable iff (!nrst)
		fetch_addr[PC_W-1:1] < 20'(PROG_WORDS) |=> fetch_data == $past(fetch_mem_data))
		else $error("fetch inside memory altered");

	// ---------------------------------------------------------------
	// Covers
	// ---------------------------------------------------------------
	push_pop_c: cover property (@(posedge clk) disable iff (!nrst) push_ev ##[1:4] pop_ev);
	overflow_c: cover property (@(posedge clk) disable iff (!nrst) full_ev);
	underflow_c: cover property (@(posedge clk) disable iff (!nrst) unf_ev);
	sw_write_c: cover property (@(posedge clk) disable iff (!nrst) sw_lo ##[1:4] pop_ev);
	discard_c: cover property (@(posedge clk) disable iff (!nrst) drop_ev && sp_ff != SP_RST);

endmodule

// [bench/ras_seq_model.sv]
// Sequencer stand-in driving the stack request port.
// Assumes the bench calls op() from one process at a time.
`timescale 1ns/1ps
module ras_seq_model (
	// Clock
	input wire logic clk,
	// Stack request
	output ras_pkg::stack_req_t req
);
	import ras_pkg::*;
	initial req = '{OP_NONE, '0};
	task automatic op(input stack_op_t o, input logic [PC_W-1:0] pc);
		@(posedge clk);
		req <= '{o, pc};
		@(posedge clk);
		req <= '{OP_NONE, '0};
	endtask
endmodule

// [bench/return_address_stack_test.sv]
// Self-checking bench for the return-address stack.
// Assumes zero-wait AHB-Lite slave and the sequencer model beside it.
`timescale 1ns/1ps
module return_address_stack_test;
	import ras_pkg::*;
	logic clk, nrst, por_n, hwrite, hready, stack_reset, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, r;
	logic [31:0] hrdata;
	logic [PC_W-1:0] fetch_addr;
	logic [15:0] fetch_mem_data, fetch_data;
	stack_req_t req, pop_data;
	int n_errors, n_checks;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	ras_seq_model u_ras_seq_model (.clk(clk), .req(req));
	return_address_stack u_return_address_stack (.clk(clk), .nrst(nrst), .por_n(por_n),
		.req(req), .pop_data(pop_data), .stack_reset(stack_reset), .fetch_addr(fetch_addr),
		.fetch_mem_data(fetch_mem_data), .fetch_data(fetch_data), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp));
	task conclude;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rdy;
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hready !== 1'b1 && i < 20);
		if (hready !== 1'b1) begin
			n_errors++;
			conclude;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		r = hrdata;
		chk(hresp, 0);
	endtask
	task pop_chk(input logic [PC_W-1:0] pc, input logic [31:0] sp);
		u_ras_seq_model.op(OP_POP, '0);
		@(negedge clk);
		chk(pop_data, {OP_POP, pc});
		bus(0, OFS_SP, 0);
		chk(r, sp);
	endtask
	task fch(input logic [PC_W-1:0] a, input logic [15:0] e);
		@(posedge clk);
		fetch_addr <= a;
		fetch_mem_data <= 16'h1234;
		@(posedge clk);
		@(negedge clk);
		chk(fetch_data, e);
	endtask
	// ----
	// Scenarios
	// ----
	// reset state
	task t_reset;
		bus(0, OFS_SP, 0);
		chk(r, 0);
		bus(0, OFS_CFG, 0);
		chk(r, {31'h0, CFG_RST});
		bus(0, 8'h14, 0);
		chk(r, 0);
		bus(0, OFS_TOP_LOW, 0);
		chk(r, 0);
		chk(pop_data, {OP_NONE, VEC_RESET});
	endtask
	task t_pushpop;
		u_ras_seq_model.op(OP_PUSH, 21'h1abcde);
		u_ras_seq_model.op(OP_PUSH, 21'h012344);
		bus(0, OFS_SP, 0);
		chk(r, 2);
		bus(0, OFS_TOP_UPPER, 0);
		chk(r, 32'h01);
		bus(0, OFS_TOP_HIGH, 0);
		chk(r, 32'h23);
		bus(1, OFS_TOP_LOW, 32'h5a);
		pop_chk(21'h01235a, 1);
		pop_chk(21'h1abcde, 0);
	endtask
	task t_under;
		pop_chk(0, 32'h40);
		u_ras_seq_model.op(OP_PUSH, 21'h000100);
		bus(0, OFS_SP, 0);
		chk(r, 32'h41);
		bus(1, OFS_SP, 0);
		bus(0, OFS_SP, 0);
		chk(r, 0);
	endtask
	task t_drop;
		u_ras_seq_model.op(OP_PUSH, 21'h000222);
		u_ras_seq_model.op(OP_PUSH, 21'h000444);
		u_ras_seq_model.op(OP_DISCARD, '0);
		@(negedge clk);
		chk(pop_data.op, OP_NONE);
		pop_chk(21'h000222, 0);
		u_ras_seq_model.op(OP_DISCARD, '0);
		bus(0, OFS_SP, 0);
		chk(r, 32'h40);
		bus(1, OFS_SP, 0);
	endtask
	task t_full;
		bus(1, OFS_CFG, 0);
		for (int k = 1; k <= 31; k++)
			u_ras_seq_model.op(OP_PUSH, 21'(k * 2));
		bus(0, OFS_SP, 0);
		chk(r, 32'h9f);
		u_ras_seq_model.op(OP_PUSH, 21'h0abcd0);
		@(negedge clk);
		chk(stack_reset, 0);
		pop_chk(21'h0abcd0, 32'h9e);
		pop_chk(21'h00003c, 32'h9d);
		bus(1, OFS_SP, 0);
	endtask
	task t_ovr;
		int i;
		bus(1, OFS_CFG, 1);
		bus(1, OFS_SP, 32'h1e);
		u_ras_seq_model.op(OP_PUSH, 21'h000400);
		i = 0;
		while (stack_reset !== 1'b1 && i < 4) begin
			@(negedge clk);
			i++;
		end
		chk(stack_reset, 1);
		if (stack_reset !== 1'b1)
			conclude;
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		bus(0, OFS_SP, 0);
		chk(r, 32'h80);
		bus(1, OFS_SP, 32'h9f);
		bus(0, OFS_TOP_LOW, 0);
		chk(r, 32'h02);
	endtask
	initial begin
		nrst = 1'b0;
		por_n = 1'b0;
		htrans = 2'h0;
		haddr = '0;
		hwrite = 1'b0;
		hwdata = '0;
		fetch_addr = '0;
		fetch_mem_data = '0;
		n_errors = 0;
		n_checks = 0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		por_n <= 1'b1;
		t_reset;
		t_pushpop;
		t_under;
		t_drop;
		t_full;
		t_ovr;
		fch(21'h007ffe, 16'h1234);
		fch(21'h008000, 16'h0000);
		fch(21'h1ffffe, 16'h0000);
		conclude;
	end
endmodule
